/* sync_serial_port.sv */
// Synchronous serial port: data buffer, control, mode and interrupt
// registers on Avalon-MM, with a shifter for 8/16-bit words.
// Assumes one core clock; pins and slow clocks are asynchronous inputs.
//
// Functional notes
// [RULE1] Buffer write loads transmit, read returns receive
// [RULE2] Start bit begins transfer, self-clears at end
// [RULE3] Software configures everything before setting start
// [RULE4] Mode bit 0 selects LSB or MSB first
// [RULE5] Mode bits 2:1 select idle/rx/tx/both
// [RULE6] Mode bit 3 selects 8 or 16 bits
// [RULE7] Mode bits 10:8 select shift clock source
// [RULE8] Internal clock means master, external means slave
// [RULE9] Mode bit 12 selects clock idle level
// [RULE10] Mode bit 13 inverts the clock output sense
// [RULE11] Software leaves mode alone during transfers
// [RULE12] External clock at most quarter core, 2 MHz
// [RULE13] No select output; a GPIO serves instead
// [RULE14] Sixteen-bit buffer, byte or word access, zero reset
// [RULE15] Interrupt raised as the start bit clears
// [RULE16] Data leaves on output pin, enters input pin
// [RULE17] Receive-only keeps output pin high
// [RULE18] Eight-bit words use only the low byte
// [RULE19] Reserved clock code never starts a transfer
`timescale 1ns/10ps
`default_nettype none

module sync_serial_port (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [sync_serial_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [sync_serial_pkg::DATA_W-1:0] avs_writedata,
	output logic [sync_serial_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic low_speed_clock,
	input wire logic oscillator_clock,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic shift_clock_pin_i,
	output logic shift_clock_pin_o,
	output logic shift_clock_pin_oe,
	output logic transfer_done_irq
);
	import sync_serial_pkg::*;

	// Transfer states
	typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_e;

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	logic ack_r; // Second cycle of a bus request
	logic req; // Read or write pending
	logic acc; // Access completes this edge
	logic wr; // Completing write
	logic [DATA_W-1:0] rdata_nxt;
	logic [DATA_W-1:0] readdata_r;
	logic [15:0] tx_hold_r; // Transmit holding register
	logic [15:0] rx_hold_r; // Receive holding register
	logic [15:0] rx_sh_r; // Bits gathered during a transfer
	logic [15:0] rx_nxt; // Gathered bits including this sample
	logic [15:0] mode_r;
	logic irq_status_r;
	logic irq_enable_r;
	xfer_state_e st_r;
	logic run; // Transfer in progress (start bit)
	logic [3:0] bit_idx_r; // Bits completed so far
	logic [3:0] last_idx;
	logic [3:0] pos; // Buffer bit for the current slot
	logic sck_act_r; // Master clock away from idle
	logic sout_r;
	logic [1:0] sin_sync_r; // Data input synchroniser
	logic msb_first;
	logic [1:0] op_sel;
	logic word16;
	logic [2:0] clk_sel;
	logic idle_type;
	logic neg_pol;
	logic master;
	logic tx_en;
	logic rx_en;
	logic idle_pin; // Pin level while the clock rests
	logic start_req;
	logic int_tick;
	logic ext_rise;
	logic ext_fall;
	logic lead_ev; // Clock leaves idle: drive next bit
	logic trail_ev; // Clock returns to idle: sample bit
	logic done_w;

	//------------------------------------------------------------------
	// Mode field decode
	//------------------------------------------------------------------
	assign msb_first = mode_r[MODE_ORDER_BIT]; // RULE4
	assign op_sel = mode_r[MODE_OP_LO +: 2]; // RULE5
	assign word16 = mode_r[MODE_LEN_BIT]; // RULE6
	assign clk_sel = mode_r[MODE_CLK_LO +: 3]; // RULE7
	assign idle_type = mode_r[MODE_IDLE_BIT]; // RULE9
	assign neg_pol = mode_r[MODE_POL_BIT]; // RULE10
	assign tx_en = op_sel[1];
	assign rx_en = op_sel[0];
	// Reserved code is neither master nor a usable slave
	assign master = (clk_sel != CLK_EXTERNAL) &&
		(clk_sel != CLK_RESERVED); // RULE8
	// Type 0 rests high, type 1 low; negative logic inverts
	assign idle_pin = ~idle_type ^ neg_pol; // RULE9 RULE10
	assign last_idx = word16 ? LAST_IDX_16 : LAST_IDX_8; // RULE6
	assign pos = msb_first ? last_idx - bit_idx_r : bit_idx_r; // RULE4
	assign run = st_r == ST_SHIFT;

	//------------------------------------------------------------------
	// Avalon-MM slave
	//------------------------------------------------------------------
	// One wait cycle per access; frozen clock keeps the master waiting
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & (~ack_r | ~clk_en);
	assign acc = req & ack_r & clk_en;
	assign wr = acc & avs_write;
	assign avs_readdata = readdata_r;

	// Wait phase marker, dropped once the access completes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_r <= 1'b0;
		end else if (clk_en) begin
			ack_r <= req & ~ack_r;
		end
	end

	// Read mux; unmapped and write-only addresses read zero
	always_comb begin
		rdata_nxt = '0;
		case (avs_address)
			BA_DATA_BUFFER: rdata_nxt[15:0] = rx_hold_r; // RULE1
			BA_CONTROL: rdata_nxt[CTL_START_BIT] = run;
			BA_MODE: rdata_nxt[15:0] = mode_r;
			BA_IRQ_STATUS: rdata_nxt[IRQ_DONE_BIT] = irq_status_r;
			BA_IRQ_ENABLE: rdata_nxt[IRQ_DONE_BIT] = irq_enable_r;
			default: rdata_nxt = '0;
		endcase
	end

	// Read data captured in the wait cycle, stands at the answer edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			readdata_r <= '0;
		end else if (clk_en && avs_read && !ack_r) begin
			readdata_r <= rdata_nxt;
		end
	end

	//------------------------------------------------------------------
	// Software registers
	//------------------------------------------------------------------
	// Buffer writes go to the transmit side only, per byte lane
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_hold_r <= BUF_RST; // RULE14
		end else if (wr && avs_address == BA_DATA_BUFFER) begin
			if (avs_byteenable[0]) begin
				tx_hold_r[7:0] <= avs_writedata[7:0]; // RULE1 RULE14
			end
			if (avs_byteenable[1]) begin
				tx_hold_r[15:8] <= avs_writedata[15:8]; // RULE14
			end
		end
	end

	// Mode register, byte or word wide
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= MODE_RST; // RULE14
		end else if (wr && avs_address == BA_MODE) begin
			if (avs_byteenable[0]) begin
				mode_r[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				mode_r[15:8] <= avs_writedata[15:8];
			end
		end
	end

	// Start refused when idle mode or reserved clock, or already busy
	assign start_req = wr && avs_address == BA_CONTROL &&
		avs_byteenable[0] && avs_writedata[CTL_START_BIT] &&
		!run && op_sel != OP_IDLE && // RULE5
		clk_sel != CLK_RESERVED; // RULE19

	//------------------------------------------------------------------
	// Transfer control
	//------------------------------------------------------------------
	// Leading edge drives a bit, trailing edge samples one
	assign lead_ev = run && (master ? (int_tick & ~sck_act_r) :
		(idle_pin ? ext_fall : ext_rise)); // RULE8
	assign trail_ev = run && (master ? (int_tick & sck_act_r) :
		(idle_pin ? ext_rise : ext_fall)); // RULE8
	assign done_w = trail_ev && bit_idx_r == last_idx; // RULE6

	// Start bit is the state; it falls with the last sample
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= ST_IDLE;
		end else if (clk_en) begin
			case (st_r)
				ST_IDLE: begin
					if (start_req) begin
						st_r <= ST_SHIFT; // RULE2
					end
				end
				ST_SHIFT: begin
					if (done_w) begin
						st_r <= ST_IDLE; // RULE2
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Bit counter, counting samples
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_idx_r <= 4'h0;
		end else if (clk_en) begin
			if (start_req) begin
				bit_idx_r <= 4'h0;
			end else if (trail_ev) begin
				bit_idx_r <= bit_idx_r + 4'h1;
			end
		end
	end

	// Master clock phase; back at idle after the last trailing edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_act_r <= 1'b0;
		end else if (clk_en) begin
			if (start_req) begin
				sck_act_r <= 1'b0;
			end else if (master && int_tick) begin
				sck_act_r <= ~sck_act_r; // RULE7
			end
		end
	end

	//------------------------------------------------------------------
	// Pins
	//------------------------------------------------------------------
	// Clock pin driven only as master in an active mode
	assign shift_clock_pin_o = idle_pin ^ sck_act_r; // RULE9 RULE10
	// Only the clock pin has an enable; chip select is a GPIO's job
	assign shift_clock_pin_oe = master && op_sel != OP_IDLE; // RULE8 RULE13
	assign serial_out_pin = sout_r;

	// Output rests high unless transmitting
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sout_r <= 1'b1;
		end else if (clk_en) begin
			if (!run || !tx_en) begin
				sout_r <= 1'b1; // RULE17
			end else if (lead_ev) begin
				sout_r <= tx_hold_r[pos]; // RULE16 RULE18
			end
		end
	end

	// Data input synchroniser; only the second stage is read by logic
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sin_sync_r <= 2'h0;
		end else if (clk_en) begin
			sin_sync_r <= {sin_sync_r[0], serial_in_pin};
		end
	end

	//------------------------------------------------------------------
	// Receive path
	//------------------------------------------------------------------
	// Gathered word including the bit sampled this cycle
	always_comb begin
		rx_nxt = rx_sh_r;
		rx_nxt[pos] = sin_sync_r[1]; // RULE16
	end

	// Sample shift store
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sh_r <= 16'h0000;
		end else if (clk_en && trail_ev && rx_en) begin
			rx_sh_r <= rx_nxt;
		end
	end

	// Holding register updated in one step at the end, never half-built
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_hold_r <= BUF_RST; // RULE14
		end else if (clk_en && done_w && rx_en) begin
			rx_hold_r[7:0] <= rx_nxt[7:0]; // RULE1
			if (word16) begin
				rx_hold_r[15:8] <= rx_nxt[15:8]; // RULE18
			end
		end
	end

	//------------------------------------------------------------------
	// Interrupts
	//------------------------------------------------------------------
	// Sticky done flag; a new event wins over a clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status_r <= 1'b0;
		end else if (clk_en) begin
			if (done_w) begin
				irq_status_r <= 1'b1; // RULE15
			end else if (wr && avs_address == BA_IRQ_CLEAR &&
				avs_byteenable[0] && avs_writedata[IRQ_DONE_BIT]) begin
				irq_status_r <= 1'b0;
			end
		end
	end

	// Enable register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_enable_r <= 1'b0;
		end else if (wr && avs_address == BA_IRQ_ENABLE &&
			avs_byteenable[0]) begin
			irq_enable_r <= avs_writedata[IRQ_DONE_BIT];
		end
	end

	assign transfer_done_irq = irq_status_r & irq_enable_r; // RULE15

	//------------------------------------------------------------------
	// Shift clock events
	//------------------------------------------------------------------
	sync_serial_clkgen u_clkgen (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.low_speed_clock(low_speed_clock),
		.oscillator_clock(oscillator_clock),
		.shift_clock_pin_i(shift_clock_pin_i),
		.clk_sel(clk_sel),
		.run(run),
		.int_tick(int_tick),
		.ext_rise(ext_rise),
		.ext_fall(ext_fall)
	);

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_last_sample;
		clk_en && done_w;
	endsequence

	sequence s_start_cleared;
		!run && irq_status_r;
	endsequence

	// End of word clears start and raises status together
	property p_done_clears;
		s_last_sample |=> s_start_cleared;
	endproperty
	a_done_clears: assert property (p_done_clears) // RULE2 RULE15
		else $error("start bit or status wrong after last bit");

	// Start accepted in an active mode leads to a running transfer
	property p_start_runs;
		clk_en && start_req |=> run && bit_idx_r == 4'h0;
	endproperty
	a_start_runs: assert property (p_start_runs) // RULE2
		else $error("accepted start did not begin a transfer");

	// Idle mode never runs
	property p_idle_mode;
		op_sel == OP_IDLE && !run |=> !run;
	endproperty
	a_idle_mode: assert property (p_idle_mode) // RULE5
		else $error("transfer began in idle mode");

	// Reserved clock never runs
	property p_reserved;
		clk_sel == CLK_RESERVED && !run |=> !run;
	endproperty
	a_reserved: assert property (p_reserved) // RULE19
		else $error("transfer began with reserved clock");

	// Receive-only keeps the data output high
	property p_rx_high;
		op_sel == OP_RX |-> serial_out_pin;
	endproperty
	a_rx_high: assert property (p_rx_high) // RULE17
		else $error("output low in receive-only mode");

	// Clock pin rests at its configured level outside transfers
	property p_clk_rest;
		!run |-> shift_clock_pin_o == (idle_type ~^ neg_pol);
	endproperty
	a_clk_rest: assert property (p_clk_rest) // RULE9 RULE10
		else $error("clock pin not at idle level");

	// Slave never drives the clock pin
	property p_slave_no_drive;
		clk_sel == CLK_EXTERNAL |-> !shift_clock_pin_oe;
	endproperty
	a_slave_no_drive: assert property (p_slave_no_drive) // RULE8
		else $error("clock pin driven in slave mode");

	// Eight-bit receive leaves the high byte alone
	property p_low_byte;
		clk_en && done_w && !word16 |=>
			rx_hold_r[15:8] == $past(rx_hold_r[15:8]);
	endproperty
	a_low_byte: assert property (p_low_byte) // RULE18
		else $error("high byte changed on 8-bit receive");

	// Buffer read answers with the receive register
	property p_buf_read;
		clk_en && avs_read && !ack_r && avs_address == BA_DATA_BUFFER
			|=> avs_readdata[15:0] == $past(rx_hold_r);
	endproperty
	a_buf_read: assert property (p_buf_read) // RULE1
		else $error("buffer read did not return receive data");

endmodule : sync_serial_port

`default_nettype wire

/* sync_serial_pkg.sv */
// Constants shared by the synchronous serial port and its clock generator.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and one
// core clock; all other clocks arrive as plain input levels.

//----------------------------------------------------------------------
// Register map, field positions, reset values, encodings
//----------------------------------------------------------------------
package sync_serial_pkg;

	// Bus geometry
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// Register indices (byte address is four times the index)
	localparam logic [15:0] IDX_DATA_BUFFER = 16'hF700;
	localparam logic [15:0] IDX_CONTROL = 16'hF702;
	localparam logic [15:0] IDX_MODE = 16'hF704;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'hF706;
	localparam logic [15:0] IDX_IRQ_ENABLE = 16'hF707;
	localparam logic [15:0] IDX_IRQ_CLEAR = 16'hF708;

	// Byte addresses seen on the bus
	localparam logic [ADDR_W-1:0] BA_DATA_BUFFER = {IDX_DATA_BUFFER, 2'b00};
	localparam logic [ADDR_W-1:0] BA_CONTROL = {IDX_CONTROL, 2'b00};
	localparam logic [ADDR_W-1:0] BA_MODE = {IDX_MODE, 2'b00};
	localparam logic [ADDR_W-1:0] BA_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] BA_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};
	localparam logic [ADDR_W-1:0] BA_IRQ_CLEAR = {IDX_IRQ_CLEAR, 2'b00};

	// Control register fields
	localparam int CTL_START_BIT = 0;

	// Mode register fields
	localparam int MODE_ORDER_BIT = 0;
	localparam int MODE_OP_LO = 1;
	localparam int MODE_LEN_BIT = 3;
	localparam int MODE_CLK_LO = 8;
	localparam int MODE_IDLE_BIT = 12;
	localparam int MODE_POL_BIT = 13;

	// Interrupt register fields
	localparam int IRQ_DONE_BIT = 0;

	// Reset values
	localparam logic [15:0] BUF_RST = 16'h0000;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [15:0] MODE_RST = 16'h0000;

	// Operation select codes
	localparam logic [1:0] OP_IDLE = 2'h0;
	localparam logic [1:0] OP_RX = 2'h1;
	localparam logic [1:0] OP_TX = 2'h2;
	localparam logic [1:0] OP_TRX = 2'h3;

	// Shift clock select codes
	localparam logic [2:0] CLK_LS_FULL = 3'h0;
	localparam logic [2:0] CLK_LS_HALF = 3'h1;
	localparam logic [2:0] CLK_OSC_4 = 3'h2;
	localparam logic [2:0] CLK_OSC_8 = 3'h3;
	localparam logic [2:0] CLK_OSC_16 = 3'h4;
	localparam logic [2:0] CLK_OSC_32 = 3'h5;
	localparam logic [2:0] CLK_EXTERNAL = 3'h6;
	localparam logic [2:0] CLK_RESERVED = 3'h7;

	// Oscillator edges per half shift period for each divider
	localparam logic [4:0] OSC_HALF_4 = 5'h02;
	localparam logic [4:0] OSC_HALF_8 = 5'h04;
	localparam logic [4:0] OSC_HALF_16 = 5'h08;
	localparam logic [4:0] OSC_HALF_32 = 5'h10;

	// Last bit index for each word length
	localparam logic [3:0] LAST_IDX_8 = 4'h7;
	localparam logic [3:0] LAST_IDX_16 = 4'hF;

endpackage : sync_serial_pkg

/* sync_serial_clkgen.sv */
// Shift clock event generator for the synchronous serial port.
// Assumes the low-speed clock, oscillator clock and clock pin are slow
// levels from other domains, sampled here on the core clock.
`timescale 1ns/10ps
`default_nettype none

module sync_serial_clkgen (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic low_speed_clock,
	input wire logic oscillator_clock,
	input wire logic shift_clock_pin_i,
	input wire logic [2:0] clk_sel,
	input wire logic run,
	output logic int_tick,
	output logic ext_rise,
	output logic ext_fall
);
	import sync_serial_pkg::*;

	//------------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------------
	// Bit 0 first stage, bit 1 second stage, bit 2 edge history
	logic [2:0] ls_sync_r;
	logic [2:0] osc_sync_r;
	logic [2:0] sck_sync_r;
	// Oscillator edge counter within one half period
	logic [4:0] osc_cnt_r;
	// Edges per half period for the selected divider
	logic [4:0] osc_half;
	logic ls_rise;
	logic ls_fall;
	logic osc_rise;
	logic osc_wrap;

	// Two stages before any logic; third only holds the last level
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ls_sync_r <= 3'h0;
			osc_sync_r <= 3'h0;
			sck_sync_r <= 3'h0;
		end else if (clk_en) begin
			ls_sync_r <= {ls_sync_r[1:0], low_speed_clock};
			osc_sync_r <= {osc_sync_r[1:0], oscillator_clock};
			sck_sync_r <= {sck_sync_r[1:0], shift_clock_pin_i};
		end
	end

	// Edges from second and third stages only
	assign ls_rise = ls_sync_r[1] & ~ls_sync_r[2];
	assign ls_fall = ~ls_sync_r[1] & ls_sync_r[2];
	assign osc_rise = osc_sync_r[1] & ~osc_sync_r[2];

	//------------------------------------------------------------------
	// Oscillator divider
	//------------------------------------------------------------------
	// Half period length per select code
	always_comb begin
		case (clk_sel)
			CLK_OSC_4: osc_half = OSC_HALF_4;
			CLK_OSC_8: osc_half = OSC_HALF_8;
			CLK_OSC_16: osc_half = OSC_HALF_16;
			CLK_OSC_32: osc_half = OSC_HALF_32;
			default: osc_half = OSC_HALF_4;
		endcase
	end

	assign osc_wrap = osc_cnt_r == osc_half - 5'h01;

	// Restarts with every transfer so the first half period is full
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_cnt_r <= 5'h00;
		end else if (clk_en) begin
			if (!run) begin
				osc_cnt_r <= 5'h00;
			end else if (osc_rise) begin
				osc_cnt_r <= osc_wrap ? 5'h00 : osc_cnt_r + 5'h01;
			end
		end
	end

	//------------------------------------------------------------------
	// Half-period ticks and pin edges
	//------------------------------------------------------------------
	// Reserved and external codes make no internal tick
	always_comb begin
		case (clk_sel)
			CLK_LS_FULL: int_tick = ls_rise | ls_fall;
			CLK_LS_HALF: int_tick = ls_rise;
			CLK_OSC_4, CLK_OSC_8, CLK_OSC_16, CLK_OSC_32:
				int_tick = osc_rise & osc_wrap;
			default: int_tick = 1'b0;
		endcase
		int_tick = int_tick & run & clk_en;
	end

	// External clock edges for slave operation
	assign ext_rise = clk_en & sck_sync_r[1] & ~sck_sync_r[2];
	assign ext_fall = clk_en & ~sck_sync_r[1] & sck_sync_r[2];

endmodule : sync_serial_clkgen

`default_nettype wire

/* spi_peer.sv */
// Behavioural far-side peripheral for the synchronous serial port.
// Assumes the port is master; sees the resolved clock pin level.
`timescale 1ns/10ps
`default_nettype none

module spi_peer (
	input wire logic sck,
	input wire logic idle_lvl,
	input wire logic mosi,
	input wire logic clr,
	input wire logic [15:0] reply,
	output logic miso,
	output logic [15:0] cap,
	output int cnt
);
	//------------------------------------------------------------
	// Frame restart, driven by the bench between transfers
	//------------------------------------------------------------
	always @(posedge clr) begin
		cnt = 0;
		cap = 16'h0000;
		miso = 1'b0;
	end

	//------------------------------------------------------------
	// Drive on leading edge, capture on trailing edge
	//------------------------------------------------------------
	// No select input here: software-driven GPIO stands in for it
	always @(sck) begin
		if (sck !== idle_lvl) begin
			miso = reply[cnt[3:0]];
		end else begin
			cap[cnt[3:0]] = mosi;
			cnt = cnt + 1;
			// Hold time over, so the line shows a changed value
			miso = ~miso;
		end
	end
endmodule : spi_peer
`default_nettype wire

/* sync_serial_port_bench.sv */
// Self-checking bench for the synchronous serial port in master mode.
// Assumes the peer model file is compiled first.
`timescale 1ns/10ps
`default_nettype none

module sync_serial_port_bench;
	import sync_serial_pkg::*;
	logic core_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	logic avs_waitrequest, lsc = 0, sin, sout, ck_o, ck_oe, irq;
	logic idle = 1, clr = 0, cen = 1, osc = 0;
	logic [3:0] be = 4'h3;
	logic [15:0] reply = 16'h0000, cap, d, mode;
	int failures = 0, cmp_count = 0, cnt, len, n, rx = 0;
	wire ck_pin = ck_oe ? ck_o : idle;

	always #50 core_clk = ~core_clk;
	always #800 lsc = ~lsc;
	always #200 osc = ~osc;

	sync_serial_port uut (.core_clk(core_clk), .arst_n(arst_n),
		.clk_en(cen), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(be),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .low_speed_clock(lsc),
		.oscillator_clock(osc), .serial_in_pin(sin),
		.serial_out_pin(sout), .shift_clock_pin_i(ck_pin),
		.shift_clock_pin_o(ck_o), .shift_clock_pin_oe(ck_oe),
		.transfer_done_irq(irq));
	spi_peer peer (.sck(ck_pin), .idle_lvl(idle), .mosi(sout), .clr(clr),
		.reply(reply), .miso(sin), .cap(cap), .cnt(cnt));

	task print_verdict;
		if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One Avalon cycle; waitrequest and data taken at the rising edge
	task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] v);
		avs_address <= a;
		avs_writedata <= v;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			failures++;
			print_verdict();
		end
		@(posedge core_clk);
	endtask : bus

	initial begin
		void'($urandom(32'h333D4334));
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		bus(0, BA_DATA_BUFFER, 0); chk(q, 0);
		bus(0, BA_CONTROL, 0); chk(q, 0);
		bus(0, BA_MODE, 0); chk(q, 0);
		// Clock idle level for every type and sense pair
		for (int k = 0; k < 4; k++) begin
			bus(1, BA_MODE, {k[1:0], 12'h004});
			chk(ck_oe, 1);
			chk(ck_o, k[1] ^ !k[0]);
		end
		// Start refused with idle op or reserved clock code
		bus(1, BA_MODE, 16'h0700 | 16'h0004);
		bus(1, BA_CONTROL, 1); bus(0, BA_CONTROL, 0); chk(q, 0);
		bus(1, BA_MODE, 16'h0000);
		chk(ck_oe, 0);
		bus(1, BA_CONTROL, 1); bus(0, BA_CONTROL, 0); chk(q, 0);
		bus(1, BA_IRQ_ENABLE, 1);
		// TX 8 LSB, TRX 16 MSB type 1, RX 8 MSB, TRX 8 LSB, TX 8 LSB from oscillator/4
		for (int t = 0; t < 5; t++) begin
			case (t)
				0: mode = 16'h0004;
				1: mode = 16'h100F;
				2: mode = 16'h2003;
				4: mode = 16'h0204;
				default: mode = 16'h0006;
			endcase
			idle = !mode[12] ^ mode[13];
			len = mode[3] ? 16 : 8;
			d = $urandom;
			reply <= $urandom;
			// Whole setup done before the start bit
			bus(1, BA_MODE, mode);
			bus(1, BA_DATA_BUFFER, d);
			clr <= 1'b1;
			@(posedge core_clk);
			clr <= 1'b0;
			bus(1, BA_CONTROL, 1);
			for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge core_clk);
			chk(irq, 1);
			if (irq !== 1'b1) print_verdict();
			bus(0, BA_CONTROL, 0); chk(q, 0);
			bus(0, BA_IRQ_STATUS, 0); chk(q[0], 1);
			chk(cnt, len);
			for (int i = 0; i < len; i++) begin
				n = mode[0] ? len - 1 - i : i;
				chk(cap[i], mode[2] ? d[n] : 1'b1);
				if (mode[1]) rx[n] = reply[i];
			end
			bus(0, BA_DATA_BUFFER, 0); chk(q, rx[15:0]);
			bus(1, BA_IRQ_ENABLE, 0); chk(irq, 0);
			bus(1, BA_IRQ_ENABLE, 1); chk(irq, 1);
			bus(1, BA_IRQ_CLEAR, 1); chk(irq, 0);
		end
		// Frozen clock enable stretches the wait phase
		cen <= 1'b0;
		fork
			bus(0, BA_MODE, 0);
			begin
				repeat (4) @(posedge core_clk);
				cen <= 1'b1;
			end
		join
		chk(q, 16'h0204); chk(n > 4, 1);
		// High byte lane alone leaves the low byte
		be <= 4'h2;
		bus(1, BA_MODE, 16'hA5C3);
		be <= 4'h3;
		bus(0, BA_MODE, 0); chk(q, 16'hA504);
		bus(0, BA_IRQ_CLEAR + 18'h00020, 0); chk(q, 0);
		print_verdict();
	end
endmodule : sync_serial_port_bench
`default_nettype wire
